// file: bhp_defines.vh
/*
 byte host port constants: address fields, queue locations, status bits, packet codes.
 assumes inclusion by bare name from the design files.
*/
`ifndef BHP_DEFINES_VH
`define BHP_DEFINES_VH
`define BHP_QUAD_IDX_HI 7
`define BHP_QUAD_IDX_LO 2
`define BHP_COMMIT_BIT 8
`define BHP_REG_IDX_W 6
`define BHP_RXREQ_IDX 6'h30
`define BHP_RXRSP_IDX 6'h31
`define BHP_ACK_IDX 6'h32
`define BHP_ACK_REQ_AV 0
`define BHP_ACK_RSP_AV 1
`define BHP_ACK_REQ_LAST 2
`define BHP_ACK_RSP_LAST 3
`define BHP_ACK_REQ_ERR 4
`define BHP_ACK_RSP_ERR 5
`define BHP_SHADOW_RST 32'h00000000
`define BHP_TC_QRD_REQ 4'h4
`define BHP_TC_WR_RSP 4'h2
`define BHP_TC_QWR_REQ 4'h0
`define BHP_TC_QRD_RSP 4'h6
`define BHP_TC_BRD_REQ 4'h5
`define BHP_TC_BWR_REQ 4'h1
`define BHP_TC_BRD_RSP 4'h7
`define BHP_TC_LOCK_REQ 4'h9
`define BHP_TC_LOCK_RSP 4'hb
`define BHP_TC_UNFMT 4'he
`define BHP_FMT_NODATA 2'h0
`define BHP_FMT_QUAD 2'h1
`define BHP_FMT_BLOCK 2'h2
`define BHP_FMT_UNFMT 2'h3
`define BHP_NODATA_HDR_QUADS 3'h3
`endif

// file: bhp_rx_buffer.v
/*
 two-entry valid/ready buffer for 33-bit receive words (last flag + quadlet).
 assumes one clock, synchronous active-low reset and a common clock enable.
*/
`default_nettype none
module bhp_rx_buffer #(
  parameter WIDTH = 33
) (
  input wire clock,
  input wire rstn,
  input wire clockEnable,
  input wire inValid,
  output wire inReady,
  input wire [WIDTH-1:0] inData,
  output wire outValid,
  input wire outReady,
  output wire [WIDTH-1:0] outData
);
  reg [WIDTH-1:0] slot0;
  reg [WIDTH-1:0] slot1;
  reg [1:0] count;
  wire push = inValid && inReady;
  wire pop = outValid && outReady;
  assign inReady = (count != 2'h2);
  assign outValid = (count != 2'h0);
  assign outData = slot0;
  always @(posedge clock) begin
    if (!rstn) begin
      count <= 2'h0;
      slot0 <= {WIDTH{1'b0}};
      slot1 <= {WIDTH{1'b0}};
    end else if (clockEnable) begin
      // slot0 is always the head
      if (pop) begin
        slot0 <= (count == 2'h2) ? slot1 : inData;
      end else if (push && count == 2'h0) begin
        slot0 <= inData;
      end
      if (push && ((count == 2'h1 && !pop) || (count == 2'h2 && pop))) begin
        slot1 <= inData;
      end
      if (push && !pop) begin
        count <= count + 2'h1;
      end else if (pop && !push) begin
        count <= count - 2'h1;
      end
    end
  end
endmodule
`default_nettype wire

// file: bhp_host_port.v
/*
 byte-wide host port: read/write shadow registers, commit to internal registers,
 receive queue draining with status and error flags, transmit layout decode.
 assumes host strobes are synchronous to clock (still double-sampled) and that
 the register file answers regRdData combinationally for regAddr.
*/
`default_nettype none
`include "bhp_defines.vh"
module bhp_host_port #(
  parameter AW = 9,
  parameter DW = 8
) (
  input wire clock,
  input wire rstn,
  input wire clockEnable,
  input wire host_select_n,
  input wire host_read_strobe_n,
  input wire host_write_strobe_n,
  input wire [AW-1:0] hostAddr,
  input wire [DW-1:0] host_data_bus_in,
  output wire [DW-1:0] host_data_bus_out,
  output wire host_data_bus_oe,
  output wire host_irq_n_out,
  output wire host_irq_n_oe,
  input wire irqRequest,
  output reg regWrite,
  output reg [`BHP_REG_IDX_W-1:0] regAddr,
  output reg [31:0] regWrData,
  input wire [31:0] regRdData,
  input wire reqValid,
  output wire reqReady,
  input wire [31:0] reqData,
  input wire reqLast,
  input wire rspValid,
  output wire rspReady,
  input wire [31:0] rspData,
  input wire rspLast,
  input wire [3:0] txTcode,
  output reg [1:0] txFormat,
  output reg [2:0] txHeaderQuads,
  output reg txTcodeBad,
  output wire [31:0] asyncIrqAck,
  input wire ackClearWrite,
  input wire [31:0] ackClearMask
);
  wire host_addr_bit0 = hostAddr[0];
  wire host_addr_bit1 = hostAddr[1];
  wire host_commit_line = hostAddr[`BHP_COMMIT_BIT];
  wire [`BHP_REG_IDX_W-1:0] quadIdx =
    hostAddr[`BHP_QUAD_IDX_HI:`BHP_QUAD_IDX_LO];
  // two-flop resample; stage 1 read only by stage 2
  reg [2:0] syncA;
  reg [2:0] syncB;
  reg rdPrev;
  reg wrPrev;
  wire rdAct = !syncB[0] && !syncB[1];
  wire wrAct = !syncB[0] && !syncB[2];
  wire rdStart = rdAct && !rdPrev;
  wire wrStart = wrAct && !wrPrev;
  reg [31:0] writeShadow;
  reg [31:0] readShadow;
  reg snapPending;
  reg [31:0] nextWriteShadow;
  reg [7:0] outByte;
  // transfer registers fed by the two-entry buffers
  wire reqBufValid;
  wire rspBufValid;
  wire [32:0] reqBufData;
  wire [32:0] rspBufData;
  wire reqPop = rdStart && host_commit_line && quadIdx == `BHP_RXREQ_IDX;
  wire rspPop = rdStart && host_commit_line && quadIdx == `BHP_RXRSP_IDX;
  reg [5:0] ackBits;
  bhp_rx_buffer #(.WIDTH(33)) reqBuffer (
    .clock(clock),
    .rstn(rstn),
    .clockEnable(clockEnable),
    .inValid(reqValid),
    .inReady(reqReady),
    .inData({reqLast, reqData}),
    .outValid(reqBufValid),
    .outReady(reqPop),
    .outData(reqBufData)
  );
  bhp_rx_buffer #(.WIDTH(33)) rspBuffer (
    .clock(clock),
    .rstn(rstn),
    .clockEnable(clockEnable),
    .inValid(rspValid),
    .inReady(rspReady),
    .inData({rspLast, rspData}),
    .outValid(rspBufValid),
    .outReady(rspPop),
    .outData(rspBufData)
  );
  always @(posedge clock) begin
    if (!rstn) begin
      syncA <= 3'h7;
      syncB <= 3'h7;
      rdPrev <= 1'b0;
      wrPrev <= 1'b0;
    end else if (clockEnable) begin
      syncA <= {host_write_strobe_n, host_read_strobe_n, host_select_n};
      syncB <= syncA;
      rdPrev <= rdAct;
      wrPrev <= wrAct;
    end
  end
  always @* begin
    nextWriteShadow = writeShadow;
    // one lane only, byte 0 is most significant
    case ({host_addr_bit1, host_addr_bit0})
      2'h0: nextWriteShadow[31:24] = host_data_bus_in;
      2'h1: nextWriteShadow[23:16] = host_data_bus_in;
      2'h2: nextWriteShadow[15:8] = host_data_bus_in;
      default: nextWriteShadow[7:0] = host_data_bus_in;
    endcase
  end
  always @(posedge clock) begin
    if (!rstn) begin
      writeShadow <= `BHP_SHADOW_RST;
      regWrite <= 1'b0;
      regAddr <= {`BHP_REG_IDX_W{1'b0}};
      regWrData <= `BHP_SHADOW_RST;
    end else if (clockEnable) begin
      regWrite <= 1'b0;
      if (wrStart) begin
        writeShadow <= nextWriteShadow;
        if (host_commit_line) begin
          // untouched bytes carry their earlier value
          regWrite <= 1'b1;
          regAddr <= quadIdx;
          regWrData <= nextWriteShadow;
        end
      end else if (rdStart && host_commit_line) begin
        regAddr <= quadIdx;
      end
    end
  end
  always @(posedge clock) begin
    if (!rstn) begin
      readShadow <= `BHP_SHADOW_RST;
      snapPending <= 1'b0;
      ackBits <= 6'h00;
    end else if (clockEnable) begin
      // snapshot a cycle late: regAddr only points at the target after the start edge
      snapPending <= rdStart && host_commit_line && !reqPop && !rspPop;
      // an empty queue read leaves the shadow alone
      if (reqPop) begin
        if (reqBufValid) begin
          readShadow <= reqBufData[31:0];
        end
      end else if (rspPop) begin
        if (rspBufValid) begin
          readShadow <= rspBufData[31:0];
        end
      end else if (snapPending) begin
        readShadow <= regRdData;
      end
      // errors are sticky; a set in the clearing cycle wins
      ackBits[`BHP_ACK_REQ_ERR] <= (ackBits[`BHP_ACK_REQ_ERR] &&
        !(ackClearWrite && ackClearMask[`BHP_ACK_REQ_ERR])) ||
        (reqPop && !reqBufValid);
      ackBits[`BHP_ACK_RSP_ERR] <= (ackBits[`BHP_ACK_RSP_ERR] &&
        !(ackClearWrite && ackClearMask[`BHP_ACK_RSP_ERR])) ||
        (rspPop && !rspBufValid);
      ackBits[`BHP_ACK_REQ_AV] <= reqBufValid;
      ackBits[`BHP_ACK_RSP_AV] <= rspBufValid;
      ackBits[`BHP_ACK_REQ_LAST] <= reqBufValid && reqBufData[32];
      ackBits[`BHP_ACK_RSP_LAST] <= rspBufValid && rspBufData[32];
    end
  end
  assign asyncIrqAck = {26'h0000000, ackBits};
  // combinational byte pick so the address may stream all four bytes
  always @* begin
    case ({host_addr_bit1, host_addr_bit0})
      2'h0: outByte = readShadow[31:24];
      2'h1: outByte = readShadow[23:16];
      2'h2: outByte = readShadow[15:8];
      default: outByte = readShadow[7:0];
    endcase
  end
  // raw pins drive the bus so data follows the strobe without delay
  assign host_data_bus_out = outByte;
  assign host_data_bus_oe = !host_select_n && !host_read_strobe_n;
  assign host_irq_n_out = 1'b0;
  assign host_irq_n_oe = irqRequest;
  always @* begin
    txTcodeBad = 1'b0;
    txHeaderQuads = 3'h4;
    case (txTcode)
      `BHP_TC_QRD_REQ, `BHP_TC_WR_RSP: begin
        txFormat = `BHP_FMT_NODATA;
        txHeaderQuads = `BHP_NODATA_HDR_QUADS;
      end
      `BHP_TC_QWR_REQ, `BHP_TC_QRD_RSP, `BHP_TC_BRD_REQ: begin
        txFormat = `BHP_FMT_QUAD;
      end
      `BHP_TC_BWR_REQ, `BHP_TC_BRD_RSP, `BHP_TC_LOCK_REQ, `BHP_TC_LOCK_RSP: begin
        txFormat = `BHP_FMT_BLOCK;
      end
      `BHP_TC_UNFMT: begin
        txFormat = `BHP_FMT_UNFMT;
        txHeaderQuads = 3'h0;
      end
      default: begin
        txFormat = `BHP_FMT_UNFMT;
        txHeaderQuads = 3'h0;
        txTcodeBad = 1'b1;
      end
    endcase
  end
endmodule
`default_nettype wire

// file: bhp_host_model.sv
/*
 host cpu model: byte reads and writes on the parallel port.
 assumes tb resolves the data wire from the port's output enable alone.
*/
`default_nettype none
module bhp_host_model (
  input wire logic clock,
  input wire logic [7:0] busIn,
  output logic selN,
  output logic rdN,
  output logic wrN,
  output logic [8:0] addr,
  output logic [7:0] dout
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    {selN, rdN, wrN} = 3'h7;
    addr = 9'h000;
    dout = 8'h00;
  end
  // strobes low 6 and high 4 cycles, above the 3-cycle resample minimum
  task automatic access(input logic w, input logic [8:0] a, input logic [7:0] d,
      output logic [7:0] q);
    @(negedge clock);
    addr = a;
    dout = d;
    {selN, rdN, wrN} = {1'b0, w, !w};
    repeat (6) @(negedge clock);
    q = busIn;
    {selN, rdN, wrN} = 3'h7;
    dout = ~d; // released lines must not look held
    repeat (4) @(negedge clock);
  endtask
endmodule
`default_nettype wire

// file: bhp_host_port_chk.sv
/*
 checker for the byte host port, watching top-level ports only.
 assumes host holds address and data while its strobe is low.
*/
`default_nettype none
module bhp_host_port_chk (
  input wire logic clock,
  input wire logic rstn,
  input wire logic clockEnable,
  input wire logic host_select_n,
  input wire logic host_read_strobe_n,
  input wire logic host_write_strobe_n,
  input wire logic [8:0] hostAddr,
  input wire logic [7:0] host_data_bus_in,
  input wire logic host_data_bus_oe,
  input wire logic host_irq_n_out,
  input wire logic host_irq_n_oe,
  input wire logic irqRequest,
  input wire logic regWrite,
  input wire logic [5:0] regAddr,
  input wire logic [31:0] regWrData,
  input wire logic reqReady,
  input wire logic [31:0] asyncIrqAck
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clock);
  endclocking
  // a frozen block answers nothing, so its windows do not count
  default disable iff (!rstn || !clockEnable);
  chk_commit_once: assert property (regWrite |=> !regWrite [*4])
    else $error("second commit within one access");
  chk_commit_delay: assert property ($fell(host_write_strobe_n) && !host_select_n && hostAddr[8]
    |-> !regWrite ##1 !regWrite ##[1:4] regWrite)
    else $error("commit not resampled or missing");
  chk_commit_cause: assert property (regWrite |-> !host_write_strobe_n && hostAddr[8])
    else $error("commit without bit8 write");
  chk_reg_index: assert property (regWrite |-> regAddr == hostAddr[7:2])
    else $error("commit index wrong");
  chk_byte_lane: assert property (regWrite
    |-> regWrData[(3 - hostAddr[1:0]) * 8 +: 8] == host_data_bus_in)
    else $error("written byte in wrong lane");
  chk_read_drive: assert property (host_data_bus_oe == (!host_select_n && !host_read_strobe_n))
    else $error("data enable wrong");
  chk_irq_drain: assert property (!host_irq_n_out && host_irq_n_oe == irqRequest)
    else $error("irq pin not open drain");
  chk_full_avail: assert property (!reqReady |-> asyncIrqAck[0])
    else $error("full queue without available bit");
endmodule
bind bhp_host_port bhp_host_port_chk chkInst (.clock, .rstn, .clockEnable, .host_select_n,
  .host_read_strobe_n, .host_write_strobe_n, .hostAddr, .host_data_bus_in,
  .host_data_bus_oe, .host_irq_n_out, .host_irq_n_oe, .irqRequest, .regWrite,
  .regAddr, .regWrData, .reqReady, .asyncIrqAck);
`default_nettype wire

// file: tb.sv
/*
 self-checking bench for the byte host port.
 assumes the register file answers combinationally, modelled here.
*/
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 0, rstn = 0, clockEnable = 1, irqRequest = 0, ackClearWrite = 0;
  logic host_select_n, host_read_strobe_n, host_write_strobe_n;
  logic [8:0] hostAddr;
  logic [7:0] host_data_bus_in, host_data_bus_out, hostDrive, q;
  logic host_data_bus_oe, host_irq_n_out, host_irq_n_oe, regWrite, txTcodeBad;
  logic [5:0] regAddr;
  logic [31:0] regWrData, regRdData, asyncIrqAck, reqData = 0, rspData = 0, ackClearMask = 0;
  logic reqValid = 0, reqReady, reqLast = 0, rspValid = 0, rspReady, rspLast = 0;
  logic [3:0] txTcode = 0;
  logic [1:0] txFormat;
  logic [2:0] txHeaderQuads;
  logic [31:0] regs [0:63];
  int err_total = 0, cmp_count = 0, cycles = 0;
  // rows: tcode, layout, unknown flag; seven bits, none spare
  localparam logic [6:0] TXROWS [11] = '{{4'h4, 2'h0, 1'b0}, {4'h2, 2'h0, 1'b0},
    {4'h0, 2'h1, 1'b0}, {4'h6, 2'h1, 1'b0}, {4'h5, 2'h1, 1'b0}, {4'h1, 2'h2, 1'b0},
    {4'h7, 2'h2, 1'b0}, {4'h9, 2'h2, 1'b0}, {4'hb, 2'h2, 1'b0}, {4'he, 2'h3, 1'b0},
    {4'h3, 2'h0, 1'b1}};
  assign host_data_bus_in = host_data_bus_oe ? host_data_bus_out : hostDrive;
  assign regRdData = regs[regAddr];
  bhp_host_model host (.clock, .busIn(host_data_bus_in), .selN(host_select_n),
    .rdN(host_read_strobe_n), .wrN(host_write_strobe_n), .addr(hostAddr), .dout(hostDrive));
  bhp_host_port DUT (.clock, .rstn, .clockEnable, .host_select_n, .host_read_strobe_n,
    .host_write_strobe_n, .hostAddr, .host_data_bus_in, .host_data_bus_out,
    .host_data_bus_oe, .host_irq_n_out, .host_irq_n_oe, .irqRequest, .regWrite, .regAddr,
    .regWrData, .regRdData, .reqValid, .reqReady, .reqData, .reqLast, .rspValid, .rspReady,
    .rspData, .rspLast, .txTcode, .txFormat, .txHeaderQuads, .txTcodeBad, .asyncIrqAck,
    .ackClearWrite, .ackClearMask);
  always #5 clock = ~clock;
  task automatic complete_run;
    $display("errors %0d compares %0d", err_total, cmp_count);
    if (err_total == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  always @(posedge clock) begin
    cycles++;
    if (regWrite)
      regs[regAddr] <= regWrData;
    if (cycles == 3000) begin
      err_total++;
      complete_run();
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %0t saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [8:0] a, input logic [7:0] d);
    host.access(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [8:0] a, input logic [7:0] exp);
    host.access(1'b0, a, 8'h00, q);
    check(q, exp);
  endtask
  task automatic push(input logic rsp, input logic [31:0] d, input logic last);
    @(negedge clock);
    if (rsp)
      {rspValid, rspData, rspLast} = {1'b1, d, last};
    else
      {reqValid, reqData, reqLast} = {1'b1, d, last};
    // ready is judged off the edge, where it has settled
    while (!(rsp ? rspReady : reqReady)) @(negedge clock);
    @(posedge clock);
    @(negedge clock);
    {reqValid, rspValid} = 2'h0;
    {reqData, rspData} = ~{reqData, rspData};
    @(negedge clock);
  endtask
  initial begin
    foreach (regs[i]) regs[i] = 32'h00000000;
    regs[6'h20] = 32'h89abcdef;
    repeat (20) @(negedge clock);
    rstn = 1;
    check(asyncIrqAck, 32'h00000000);
    foreach (TXROWS[i]) begin
      @(negedge clock);
      txTcode = TXROWS[i][6:3];
      #1;
      check(txTcodeBad, TXROWS[i][0]);
      if (!TXROWS[i][0]) check(txFormat, TXROWS[i][2:1]);
      if (TXROWS[i][2:0] == 3'h0) check(txHeaderQuads, 3'h3);
    end
    wr(9'h14f, 8'h5a);
    check(regs[6'h13], 32'h0000005a);
    wr(9'h04c, 8'h11);
    wr(9'h04d, 8'h22);
    wr(9'h04e, 8'h33);
    wr(9'h04c, 8'h44);
    check(regs[6'h13], 32'h0000005a);
    wr(9'h14f, 8'h55);
    check(regs[6'h13], 32'h44223355);
    wr(9'h14d, 8'h66);
    check(regs[6'h13], 32'h44663355);
    for (int k = 0; k < 4; k++)
      wr({k == 3, 6'h05, 2'(k)}, 8'(8'h10 + k));
    check(regs[6'h05], 32'h10111213);
    clockEnable = 0;
    wr(9'h105, 8'h99);
    clockEnable = 1;
    check(regs[6'h01], 32'h00000000);
    rd(9'h180, 8'h89);
    regs[6'h20] = 32'h00000000; // shadow must keep the snapshot
    rd(9'h083, 8'hef);
    push(1'b0, 32'ha1b2c3d4, 1'b0);
    push(1'b0, 32'h0f1e2d3c, 1'b1);
    check(reqReady, 1'b0);
    check(asyncIrqAck[2:0], 3'h1);
    rd(9'h1c0, 8'ha1);
    rd(9'h0c1, 8'hb2);
    rd(9'h0c2, 8'hc3);
    check(asyncIrqAck[2:0], 3'h5);
    rd(9'h1c3, 8'h3c);
    rd(9'h1c0, 8'h0f);
    check(asyncIrqAck[5:0], 6'h10);
    {ackClearWrite, ackClearMask} = {1'b1, 32'h00000010};
    @(negedge clock);
    ackClearWrite = 0;
    irqRequest = 1;
    @(negedge clock);
    check(asyncIrqAck[5:0], 6'h00);
    push(1'b1, 32'h77665544, 1'b1);
    irqRequest = 0;
    check(rspReady, 1'b1);
    check(asyncIrqAck[3:0], 4'ha);
    rd(9'h1c5, 8'h66);
    complete_run();
  end
endmodule
`default_nettype wire
